// >>> rtl/cif_params.svh
// offsets, field positions and reset values for the can id filter
// assumes a 32-bit register port with byte addresses below 0x100
//
// What this block does
// - A received identifier passes only where it equals the filter at every bit the mask sets.
// - Filter and mask sit in 29-bit storage for 29-bit ids, and 11-bit ids use the low 11 bits.
// - In 11-bit mode bits above the eleventh of a written filter or mask are dropped.
// - The short filter and mask writes take three hex digits and keep only their low 11 bits, in either id mode.
// - The exact id write loads the filter with the id and the mask with all relevant ones.
// - A frame is shown only when the id filter and any active byte monitor both match.
// - While any monitor mode is on, the bus acknowledge and error signalling stay off.
// - The filter applies to every frame, and a request with no passing reply flags no data.
// - Restoring defaults returns filter and mask to the pass-all state.
// - Formatted segment lines carry the hex sequence digit 0 to F, wrapping.
// - Formatted first frames give a separate length line ahead of their segment line.
// - The upper nibble of the control byte marks 1 first and 2 consecutive frames.
// - Response formatting is on after reset.
// - Formatting strips the control byte unless header display is on.
// - The first-frame length is a 12-bit field, at most 4095 bytes.
`ifndef CIF_PARAMS_SVH
`define CIF_PARAMS_SVH

// ==========================================
// register offsets
`define CIF_REG_CTRL      8'h00
`define CIF_REG_FILTER    8'h04
`define CIF_REG_MASK      8'h08
`define CIF_REG_MONBYTE   8'h0C
`define CIF_REG_EXACT     8'h10
`define CIF_REG_SHORTF    8'h14
`define CIF_REG_SHORTM    8'h18
`define CIF_REG_RESTORE   8'h1C
`define CIF_REG_STATUS    8'h20
`define CIF_REG_COUNT     8'h24

// ==========================================
// control fields
`define CIF_CTRL_CAF      0
`define CIF_CTRL_HDR      1
`define CIF_CTRL_EXT      2
`define CIF_CTRL_MON_LO   4
`define CIF_CTRL_MON_HI   5

// ==========================================
// reset values
`define CIF_CAF_RST       1'b1
`define CIF_HDR_RST       1'b0
`define CIF_EXT_RST       1'b0
`define CIF_FILTER_RST    29'h0000000
`define CIF_MASK_RST      29'h0000000
`define CIF_MONBYTE_RST   8'h00
`define CIF_ID29_ONES     29'h1FFFFFFF
`define CIF_ID11_ONES     29'h00007FF

// ==========================================
// control byte codes
`define CIF_PCI_SINGLE    4'h0
`define CIF_PCI_FIRST     4'h1
`define CIF_PCI_CONSEC    4'h2

`endif

// >>> rtl/cif_pkg.sv
// types shared by the can id filter files
// assumes cif_params.svh supplies the numbers
package cif_pkg;

  typedef enum logic [1:0] {
    MON_OFF,
    MON_ALL,
    MON_RECV,
    MON_SEND
  } mon_type;

  typedef enum logic [1:0] {
    LINE_RAW,
    LINE_LEN,
    LINE_SEG,
    LINE_SINGLE
  } line_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FIRST,
    ST_SECOND
  } state_type;

  typedef struct packed {
    line_type    kind;
    logic [3:0]  seq;
    logic [28:0] id;
    logic        hdr;
    logic [11:0] count;
    logic [63:0] data;
  } rec_type;

endpackage

// >>> rtl/cif_fifo.sv
// small shift fifo, head word held in a flop
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
module cif_fifo #(
  parameter int Width = 8,
  parameter int Depth = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             inValid,
  output wire logic             inReady,
  input  wire logic [Width-1:0] inData,
  output wire logic             outValid,
  input  wire logic             outReady,
  output wire logic [Width-1:0] outData
);
  localparam int CntW = $clog2(Depth + 1);

  // ==========================================
  // occupancy
  logic [Width-1:0] mem_q [Depth];
  logic [CntW-1:0]  cnt_q;
  wire              push  = inValid && inReady;
  wire              pop   = outValid && outReady;
  wire  [CntW-1:0]  wrIdx = cnt_q - CntW'(pop);

  assign inReady  = cnt_q != CntW'(Depth);
  assign outValid = cnt_q != '0;
  assign outData  = mem_q[0];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CntW'(push) - CntW'(pop);
    end
  end

  // ==========================================
  // storage, shifts toward the head
  for (genvar i = 0; i < Depth; i++) begin : gSlot
    always_ff @(posedge clk_sys) begin
      if (rst) begin
        mem_q[i] <= '0;
      end else if (push && wrIdx == CntW'(i)) begin
        mem_q[i] <= inData;
      end else if (pop && i < Depth - 1) begin
        mem_q[i] <= mem_q[(i + 1) % Depth];
      end
    end
  end
endmodule

// >>> rtl/cif_id_match.sv
// identifier filter and monitor byte comparison
// assumes all inputs from the same clock domain
`timescale 1ns/1ps
`include "cif_params.svh"
module cif_id_match (
  input  wire logic            [28:0] id,
  input  wire logic                   ext,
  input  wire logic            [28:0] filter,
  input  wire logic            [28:0] mask,
  input  wire cif_pkg::mon_type       monMode,
  input  wire logic            [7:0]  monByte,
  output wire logic                   hit
);
  // ==========================================
  // id filter
  wire [28:0] span   = ext ? `CIF_ID29_ONES : `CIF_ID11_ONES;
  wire        idOk   = ((id ^ filter) & mask & span) == 29'h0000000;

  // ==========================================
  // monitor byte, 11-bit ids keep 3 receiver bits
  wire [7:0]  rxByte = ext ? id[15:8] : {5'h00, id[10:8]};
  wire [7:0]  wantRx = ext ? monByte : {5'h00, monByte[2:0]};
  wire        rxOk   = rxByte == wantRx;
  wire        txOk   = id[7:0] == monByte;
  wire        monOk  = (monMode == cif_pkg::MON_RECV) ? rxOk :
                       (monMode == cif_pkg::MON_SEND) ? txOk : 1'b1;

  assign hit = idOk && monOk;
endmodule

// >>> rtl/cif_filter_top.sv
// can receive filter and response line formatter
// assumes frames and register port on clk_sys, fifo drained by a printer
`timescale 1ns/1ps
`include "cif_params.svh"
module cif_filter_top #(
  parameter int FifoDepth = 4
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output wire logic [31:0] regRdata,
  input  wire logic        rxValid,
  output wire logic        rxReady,
  input  wire logic [28:0] rxId,
  input  wire logic        rxExt,
  input  wire logic [3:0]  rxLen,
  input  wire logic [63:0] rxData,
  input  wire logic        reqStart,
  input  wire logic        reqEnd,
  output wire logic        noData,
  output wire logic        busSilent,
  output wire logic        outValid,
  input  wire logic        outReady,
  output wire logic [1:0]  outKind,
  output wire logic [3:0]  outSeq,
  output wire logic [28:0] outId,
  output wire logic        outHdr,
  output wire logic [11:0] outCount,
  output wire logic [63:0] outData
);
  localparam int RecW = $bits(cif_pkg::rec_type);

  // ==========================================
  // helpers
  function automatic logic [28:0] fitId(input logic [31:0] v, input logic ext);
    return ext ? v[28:0] : {18'h00000, v[10:0]};
  endfunction

  function automatic logic [11:0] bodyCnt(input logic [3:0] len, input logic [3:0] skip);
    logic [3:0] diff;
    diff = len - skip;
    return (len > skip) ? {8'h00, diff} : 12'h000;
  endfunction

  function automatic cif_pkg::rec_type mkRec(
    input cif_pkg::line_type kind,
    input logic [3:0]        seq,
    input logic [28:0]       id,
    input logic              hdr,
    input logic [11:0]       count,
    input logic [63:0]       data
  );
    cif_pkg::rec_type r;
    r.kind  = kind;
    r.seq   = seq;
    r.id    = id;
    r.hdr   = hdr;
    r.count = count;
    r.data  = data;
    return r;
  endfunction

  // ==========================================
  // register state
  logic                    cafOn_q;
  logic                    hdrOn_q;
  logic                    extMode_q;
  cif_pkg::mon_type        monMode_q;
  logic [28:0]             filter_q;
  logic [28:0]             mask_q;
  logic [7:0]              monByte_q;
  logic [31:0]             regRdata_q;
  logic                    cafOn_d;
  logic                    hdrOn_d;
  logic                    extMode_d;
  cif_pkg::mon_type        monMode_d;
  logic [28:0]             filter_d;
  logic [28:0]             mask_d;
  logic [7:0]              monByte_d;
  logic [31:0]             rdSel;

  wire wrCtrl    = regWr && regAddr == `CIF_REG_CTRL;
  wire wrFilter  = regWr && regAddr == `CIF_REG_FILTER;
  wire wrMask    = regWr && regAddr == `CIF_REG_MASK;
  wire wrMonByte = regWr && regAddr == `CIF_REG_MONBYTE;
  wire wrExact   = regWr && regAddr == `CIF_REG_EXACT;
  wire wrShortF  = regWr && regAddr == `CIF_REG_SHORTF;
  wire wrShortM  = regWr && regAddr == `CIF_REG_SHORTM;
  wire wrRestore = regWr && regAddr == `CIF_REG_RESTORE;

  // ==========================================
  // frame path state
  cif_pkg::state_type      state_q;
  cif_pkg::state_type      state_d;
  cif_pkg::rec_type        recA_q;
  cif_pkg::rec_type        recB_q;
  cif_pkg::rec_type        recA_d;
  cif_pkg::rec_type        recB_d;
  logic                    two_q;
  logic                    two_d;
  logic                    seenAny_q;
  logic                    noData_q;
  logic                    silent_q;
  logic [15:0]             passCnt_q;
  logic [15:0]             dropCnt_q;
  logic                    hit;
  logic                    fifoInReady;
  logic                    fifoOutValid;
  logic [RecW-1:0]         fifoOut;

  // ==========================================
  // configuration updates
  always_comb begin
    cafOn_d   = cafOn_q;
    hdrOn_d   = hdrOn_q;
    extMode_d = extMode_q;
    monMode_d = monMode_q;
    filter_d  = filter_q;
    mask_d    = mask_q;
    monByte_d = monByte_q;
    if (wrRestore) begin
      cafOn_d   = `CIF_CAF_RST;
      hdrOn_d   = `CIF_HDR_RST;
      extMode_d = `CIF_EXT_RST;
      monMode_d = cif_pkg::MON_OFF;
      filter_d  = `CIF_FILTER_RST;
      mask_d    = `CIF_MASK_RST;
      monByte_d = `CIF_MONBYTE_RST;
    end else if (wrCtrl) begin
      cafOn_d   = regWdata[`CIF_CTRL_CAF];
      hdrOn_d   = regWdata[`CIF_CTRL_HDR];
      extMode_d = regWdata[`CIF_CTRL_EXT];
      monMode_d = cif_pkg::mon_type'(regWdata[`CIF_CTRL_MON_HI:`CIF_CTRL_MON_LO]);
    end else if (wrFilter) begin
      filter_d  = fitId(regWdata, extMode_q);
    end else if (wrMask) begin
      mask_d    = fitId(regWdata, extMode_q);
    end else if (wrShortF) begin
      filter_d  = fitId({20'h00000, regWdata[11:0]}, 1'b0);
    end else if (wrShortM) begin
      mask_d    = fitId({20'h00000, regWdata[11:0]}, 1'b0);
    end else if (wrExact) begin
      filter_d  = fitId(regWdata, extMode_q);
      mask_d    = extMode_q ? `CIF_ID29_ONES : `CIF_ID11_ONES;
    end else if (wrMonByte) begin
      monByte_d = regWdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cafOn_q   <= `CIF_CAF_RST;
      hdrOn_q   <= `CIF_HDR_RST;
      extMode_q <= `CIF_EXT_RST;
      monMode_q <= cif_pkg::MON_OFF;
      filter_q  <= `CIF_FILTER_RST;
      mask_q    <= `CIF_MASK_RST;
      monByte_q <= `CIF_MONBYTE_RST;
    end else begin
      cafOn_q   <= cafOn_d;
      hdrOn_q   <= hdrOn_d;
      extMode_q <= extMode_d;
      monMode_q <= monMode_d;
      filter_q  <= filter_d;
      mask_q    <= mask_d;
      monByte_q <= monByte_d;
    end
  end

  // ==========================================
  // register read
  always_comb begin
    case (regAddr)
      `CIF_REG_CTRL:    rdSel = {26'h0000000, monMode_q, 1'b0, extMode_q, hdrOn_q, cafOn_q};
      `CIF_REG_FILTER:  rdSel = {3'h0, filter_q};
      `CIF_REG_MASK:    rdSel = {3'h0, mask_q};
      `CIF_REG_MONBYTE: rdSel = {24'h000000, monByte_q};
      `CIF_REG_STATUS:  rdSel = {29'h00000000, fifoOutValid, seenAny_q, silent_q};
      `CIF_REG_COUNT:   rdSel = {dropCnt_q, passCnt_q};
      default:          rdSel = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      regRdata_q <= 32'h00000000;
    end else begin
      regRdata_q <= regRd ? rdSel : 32'h00000000;
    end
  end

  assign regRdata = regRdata_q;

  // ==========================================
  // acceptance
  cif_id_match uMatch (
    .id      (rxId),
    .ext     (rxExt),
    .filter  (filter_q),
    .mask    (mask_q),
    .monMode (monMode_q),
    .monByte (monByte_q),
    .hit     (hit)
  );

  assign rxReady = state_q == cif_pkg::ST_IDLE;
  wire take      = rxValid && rxReady;
  wire keep      = take && hit;

  // ==========================================
  // line building
  wire [3:0]  pciHi = rxData[63:60];
  wire [3:0]  pciLo = rxData[59:56];
  wire [11:0] ffLen = {pciLo, rxData[55:48]};
  wire        raw   = !cafOn_q || hdrOn_q;

  always_comb begin
    recA_d = mkRec(cif_pkg::LINE_RAW, 4'h0, rxId, hdrOn_q, {8'h00, rxLen}, rxData);
    recB_d = recA_d;
    two_d  = 1'b0;
    if (!raw) begin
      case (pciHi)
        `CIF_PCI_FIRST: begin
          recA_d = mkRec(cif_pkg::LINE_LEN, 4'h0, rxId, 1'b0, ffLen, 64'h0);
          recB_d = mkRec(cif_pkg::LINE_SEG, 4'h0, rxId, 1'b0,
                         bodyCnt(rxLen, 4'h2), rxData << 16);
          two_d  = 1'b1;
        end
        `CIF_PCI_CONSEC: begin
          recA_d = mkRec(cif_pkg::LINE_SEG, pciLo, rxId, 1'b0,
                         bodyCnt(rxLen, 4'h1), rxData << 8);
        end
        `CIF_PCI_SINGLE: begin
          recA_d = mkRec(cif_pkg::LINE_SINGLE, 4'h0, rxId, 1'b0,
                         {8'h00, pciLo}, rxData << 8);
        end
        default: begin
          recA_d = mkRec(cif_pkg::LINE_RAW, 4'h0, rxId, 1'b0, {8'h00, rxLen}, rxData);
        end
      endcase
    end
  end

  // ==========================================
  // emission sequence
  wire pushing = state_q != cif_pkg::ST_IDLE && fifoInReady;

  always_comb begin
    state_d = state_q;
    case (state_q)
      cif_pkg::ST_IDLE: begin
        if (keep) begin
          state_d = cif_pkg::ST_FIRST;
        end
      end
      cif_pkg::ST_FIRST: begin
        if (pushing) begin
          state_d = two_q ? cif_pkg::ST_SECOND : cif_pkg::ST_IDLE;
        end
      end
      cif_pkg::ST_SECOND: begin
        if (pushing) begin
          state_d = cif_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = cif_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= cif_pkg::ST_IDLE;
      recA_q  <= '0;
      recB_q  <= '0;
      two_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (keep) begin
        recA_q <= recA_d;
        recB_q <= recB_d;
        two_q  <= two_d;
      end
    end
  end

  // ==========================================
  // no-data tracking, a pass beats a request start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seenAny_q <= 1'b0;
      noData_q  <= 1'b0;
      passCnt_q <= 16'h0000;
      dropCnt_q <= 16'h0000;
    end else begin
      seenAny_q <= keep || (seenAny_q && !reqStart);
      noData_q  <= reqEnd && !seenAny_q && !keep;
      passCnt_q <= passCnt_q + 16'(keep);
      dropCnt_q <= dropCnt_q + 16'(take && !hit);
    end
  end

  assign noData = noData_q;

  // ==========================================
  // bus silence while monitoring
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      silent_q <= 1'b0;
    end else begin
      silent_q <= monMode_d != cif_pkg::MON_OFF;
    end
  end

  assign busSilent = silent_q;

  // ==========================================
  // output queue
  cif_fifo #(
    .Width (RecW),
    .Depth (FifoDepth)
  ) uFifo (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (state_q != cif_pkg::ST_IDLE),
    .inReady  (fifoInReady),
    .inData   (state_q == cif_pkg::ST_SECOND ? recB_q : recA_q),
    .outValid (fifoOutValid),
    .outReady (outReady),
    .outData  (fifoOut)
  );

  cif_pkg::rec_type headRec;
  assign headRec  = cif_pkg::rec_type'(fifoOut);
  assign outValid = fifoOutValid;
  assign outKind  = headRec.kind;
  assign outSeq   = headRec.seq;
  assign outId    = headRec.id;
  assign outHdr   = headRec.hdr;
  assign outCount = headRec.count;
  assign outData  = headRec.data;
endmodule

// >>> dv/cif_filter_top_chk.sv
// checker for the can id filter top
// assumes a bind onto cif_filter_top, one clock domain
`timescale 1ns/1ps
module cif_filter_top_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  regAddr,
  input wire logic [31:0] regWdata,
  input wire logic        regWr,
  input wire logic        rxValid,
  input wire logic        rxReady,
  input wire logic        reqEnd,
  input wire logic        noData,
  input wire logic        busSilent,
  input wire logic        outValid,
  input wire logic        outReady,
  input wire logic [1:0]  outKind,
  input wire logic [3:0]  outSeq,
  input wire logic        outHdr,
  input wire logic [63:0] outData
);
  // ======================================
  // pass-all shadow and properties
  logic allPass_q;
  logic allPass_d;
  wire  ctrlWr = regWr && regAddr == 8'h00;
  wire  restWr = regWr && regAddr == 8'h1C;
  wire  cutWr  = regWr && (regAddr == 8'h08 || regAddr == 8'h10 || regAddr == 8'h18);
  wire  monOn  = regWdata[5:4] != 2'h0;
  assign allPass_d = restWr ? 1'b1 : (cutWr || (ctrlWr && monOn)) ? 1'b0 : allPass_q;
  always_ff @(posedge clk_sys) begin
    if (rst) allPass_q <= 1'b1;
    else allPass_q <= allPass_d;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_pass_all: assert property (allPass_q && rxValid && rxReady |=> !rxReady)
    else $error("frame not kept with pass-all filter");
  a_mon_silent: assert property (ctrlWr |=> busSilent == $past(monOn))
    else $error("bus silence differs from monitor mode");
  a_restore_quiet: assert property (restWr |=> !busSilent)
    else $error("bus still silent after restore");
  a_silent_cause: assert property ($changed(busSilent) |-> $past(regWr)
    && ($past(regAddr) == 8'h00 || $past(regAddr) == 8'h1C))
    else $error("bus silence changed without a write");
  a_nodata_cause: assert property (noData |-> $past(reqEnd))
    else $error("no-data flag without request end");
  a_out_hold: assert property (outValid && !outReady |=> outValid
    && $stable(outData) && $stable(outKind))
    else $error("output head changed while stalled");
  a_len_seg: assert property (outValid && outReady && outKind == 2'h1
    |-> ##[1:2] (outValid && outKind == 2'h2 && outSeq == 4'h0))
    else $error("length line not followed by segment zero");
  a_hdr_raw: assert property (outValid && outHdr |-> outKind == 2'h0)
    else $error("header line not raw");
endmodule
bind cif_filter_top cif_filter_top_chk cif_filter_top_chk_inst (.clk_sys, .rst, .regAddr,
  .regWdata, .regWr, .rxValid, .rxReady, .reqEnd, .noData, .busSilent, .outValid,
  .outReady, .outKind, .outSeq, .outHdr, .outData);

// >>> dv/cif_can_ecu.sv
// ecu side model offering received can frames
// assumes frames queued by the bench through put, one clock
`timescale 1ns/1ps
module cif_can_ecu (
  input  wire logic   clk_sys,
  input  wire logic   rst,
  input  wire logic   slow,
  input  wire logic   rxReady,
  output logic        rxValid,
  output logic [28:0] rxId,
  output logic        rxExt,
  output logic [3:0]  rxLen,
  output logic [63:0] rxData
);
  // ======================================
  // frame queue and offer
  logic [97:0] frames[$];
  logic [1:0]  gap_q;
  initial {rxValid, rxId, rxExt, rxLen, rxData, gap_q} = '0;
  task automatic put(input logic [28:0] i, input logic e, input logic [3:0] l,
                     input logic [63:0] d);
    frames.push_back({i, e, l, d});
  endtask
  function automatic int pending();
    return frames.size() + int'(rxValid);
  endfunction
  always @(posedge clk_sys) begin
    if (rst) begin
      rxValid <= 1'b0;
      gap_q   <= 2'h0;
    end else if (rxValid) begin
      if (rxReady) begin
        rxValid <= 1'b0;
        rxData  <= ~rxData;
        rxId    <= ~rxId;
      end
    end else if (gap_q != 2'h0 || frames.size() == 0) begin
      gap_q  <= (gap_q != 2'h0) ? gap_q - 2'h1 : 2'h0;
      rxData <= ~rxData;
    end else begin
      {rxId, rxExt, rxLen, rxData} <= frames.pop_front();
      rxValid <= 1'b1;
      gap_q   <= slow ? 2'($urandom) : 2'h0;
    end
  end
endmodule

// >>> dv/cif_filter_top_test.sv
// self-checking bench for the can id filter top
// assumes cif_can_ecu on the frame side, bench drains the output
`timescale 1ns/1ps
module cif_filter_top_test;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        reqStart = 1'b0;
  logic        reqEnd = 1'b0;
  logic        outReady = 1'b0;
  logic        slow = 1'b0;
  logic        ext = 1'b0;
  logic [31:0] regRdata;
  logic        rxValid, rxReady, rxExt, noData, busSilent, outValid, outHdr;
  logic [28:0] rxId, outId, f, m, id;
  logic [3:0]  rxLen, outSeq;
  logic [63:0] rxData, outData, d;
  logic [1:0]  outKind;
  logic [11:0] outCount;
  int          err_total = 0;
  int          checked = 0;
  always #2.5 clk_sys = ~clk_sys;
  cif_filter_top #(.FifoDepth(4)) cif_filter_top_inst (.clk_sys, .rst, .regAddr, .regWdata,
    .regWr, .regRd, .regRdata, .rxValid, .rxReady, .rxId, .rxExt, .rxLen, .rxData,
    .reqStart, .reqEnd, .noData, .busSilent, .outValid, .outReady, .outKind, .outSeq,
    .outId, .outHdr, .outCount, .outData);
  cif_can_ecu ecu (.clk_sys, .rst, .slow, .rxReady, .rxValid, .rxId, .rxExt, .rxLen, .rxData);
  // ======================================
  // tasks
  task automatic results();
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  function automatic logic pass(input logic [28:0] i);
    return ((i ^ f) & m) == 29'h0;
  endfunction
  function automatic logic [63:0] keep(input logic [11:0] c);
    return ~(64'hFFFFFFFFFFFFFFFF >> (8 * c));
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1 cmp("regRdata", 64'(e), 64'(regRdata));
  endtask
  task automatic pulse(input logic e);
    @(posedge clk_sys);
    reqEnd   <= e;
    reqStart <= !e;
    @(posedge clk_sys);
    reqEnd   <= 1'b0;
    reqStart <= 1'b0;
    #1;
  endtask
  task automatic rec(input logic [1:0] k, input logic [3:0] s, input logic [28:0] i,
                     input logic [11:0] c, input logic [63:0] v, input logic h);
    int n;
    n = 0;
    while (outValid !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      #1 n++;
    end
    if (n >= 100) err_total++;
    cmp("outRec", 64'({k, (k == 2'h2) ? s : 4'h0, i, c, h}),
        64'({outKind, (k == 2'h2) ? outSeq : 4'h0, outId, outCount, outHdr}));
    if (k != 2'h1) cmp("outData", v & keep(c), outData & keep(c));
    @(posedge clk_sys) outReady <= 1'b1;
    @(posedge clk_sys) outReady <= 1'b0;
    #1;
  endtask
  task automatic frame(input logic [28:0] i, input logic [63:0] v, input logic p);
    int n;
    ecu.put(i, ext, 4'h8, v);
    n = 0;
    while (ecu.pending() != 0 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 200) err_total++;
    repeat (4) @(posedge clk_sys);
    #1 cmp("outValid", 64'(p), 64'(outValid));
  endtask
  // ======================================
  // sequence
  initial begin
    #400us;
    err_total++;
    results();
  end
  initial begin
    void'($urandom(32'h89094d8c));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h00, 32'h1);
    rd(8'h30, 32'h0);
    wr(8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'h7FF);
    wr(8'h14, 32'hF00);
    rd(8'h04, 32'h700);
    wr(8'h00, 32'h4);
    ext = 1'b1;
    f = 29'($urandom);
    m = 29'($urandom) | 29'h1;
    wr(8'h04, {3'h0, f});
    wr(8'h08, {3'h0, m});
    rd(8'h08, {3'h0, m});
    for (int i = 0; i < 24; i++) begin
      id = (i % 3 == 0) ? f ^ (29'($urandom) & ~m) : 29'($urandom);
      if (i % 3 == 1) id = f ^ (m & (~m + 29'h1));
      d = {$urandom, $urandom};
      slow <= 1'($urandom);
      frame(id, d, pass(id));
      if (pass(id)) rec(2'h0, 4'h0, id, 12'h8, d, 1'b0);
    end
    ext = 1'b0;
    wr(8'h1C, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h00, 32'h1);
    wr(8'h10, 32'h7E9);
    rd(8'h08, 32'h7FF);
    frame(29'h7E8, 64'h0341054600000000, 1'b0);
    frame(29'h7E9, 64'h0341054600000000, 1'b1);
    rec(2'h3, 4'h0, 29'h7E9, 12'h3, 64'h4105460000000000, 1'b0);
    wr(8'h1C, 32'h0);
    ecu.put(29'h7E8, 1'b0, 4'h8, 64'h1013490401353630);
    ecu.put(29'h7E9, 1'b0, 4'h8, 64'h1FFF490401353630);
    ecu.put(29'h7E8, 1'b0, 4'h8, 64'h2132383934394143);
    ecu.put(29'h7E8, 1'b0, 4'h8, 64'h2F00000000000031);
    ecu.put(29'h7E9, 1'b0, 4'h8, 64'h2032383935344143);
    repeat (40) @(posedge clk_sys);
    #1 cmp("rxReady", 64'h0, 64'(rxReady));
    rec(2'h1, 4'h0, 29'h7E8, 12'h013, 64'h0, 1'b0);
    rec(2'h2, 4'h0, 29'h7E8, 12'h6, 64'h4904013536300000, 1'b0);
    rec(2'h1, 4'h0, 29'h7E9, 12'hFFF, 64'h0, 1'b0);
    rec(2'h2, 4'h0, 29'h7E9, 12'h6, 64'h4904013536300000, 1'b0);
    rec(2'h2, 4'h1, 29'h7E8, 12'h7, 64'h3238393439414300, 1'b0);
    rec(2'h2, 4'hF, 29'h7E8, 12'h7, 64'h0000000000003100, 1'b0);
    rec(2'h2, 4'h0, 29'h7E9, 12'h7, 64'h3238393534414300, 1'b0);
    wr(8'h00, 32'h3);
    frame(29'h7E8, 64'h1013490401353630, 1'b1);
    rec(2'h0, 4'h0, 29'h7E8, 12'h8, 64'h1013490401353630, 1'b1);
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, {26'h0, 2'(k), 4'h1});
      #1 cmp("busSilent", 64'(k != 0), 64'(busSilent));
    end
    wr(8'h14, 32'h600);
    wr(8'h18, 32'h700);
    wr(8'h0C, 32'hE8);
    frame(29'h7E8, 64'h0341054600000000, 1'b0);
    frame(29'h6E9, 64'h0341054600000000, 1'b0);
    frame(29'h6E8, 64'h0341054600000000, 1'b1);
    rec(2'h3, 4'h0, 29'h6E8, 12'h3, 64'h4105460000000000, 1'b0);
    wr(8'h00, 32'h21);
    wr(8'h0C, 32'h5);
    frame(29'h6E9, 64'h0341054600000000, 1'b0);
    wr(8'h0C, 32'h6);
    frame(29'h6E9, 64'h0341054600000000, 1'b1);
    rec(2'h3, 4'h0, 29'h6E9, 12'h3, 64'h4105460000000000, 1'b0);
    @(posedge clk_sys) rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 cmp("busSilent", 64'h0, 64'(busSilent));
    rd(8'h00, 32'h1);
    wr(8'h1C, 32'h0);
    #1 cmp("busSilent", 64'h0, 64'(busSilent));
    wr(8'h10, 32'h7E9);
    pulse(1'b0);
    frame(29'h7E8, 64'h0341054600000000, 1'b0);
    pulse(1'b1);
    cmp("noData", 64'h1, 64'(noData));
    pulse(1'b0);
    frame(29'h7E9, 64'h0341054600000000, 1'b1);
    rec(2'h3, 4'h0, 29'h7E9, 12'h3, 64'h4105460000000000, 1'b0);
    pulse(1'b1);
    cmp("noData", 64'h0, 64'(noData));
    rd(8'h20, 32'h2);
    rd(8'h24, 32'h00010001);
    results();
  end
endmodule
